// ==== rtl/pap_pkg.sv ====
package pap_pkg;

  // Register indices, byte address is four times the index
  localparam logic [4:0] IDX_STATUS_A = 5'h00;
  localparam logic [4:0] IDX_STATUS_B = 5'h01;
  localparam logic [4:0] IDX_DRIVE_OUT_CTRL = 5'h02;
  localparam logic [4:0] IDX_RATE_SEL_MAIN_STAT = 5'h04;
  localparam logic [4:0] IDX_CMD_DATA = 5'h05;
  localparam logic [4:0] IDX_DISK_IN_CFG_CTRL = 5'h07;
  localparam logic [4:0] IDX_AUTO_PD_CFG = 5'h10;
  localparam logic [4:0] IDX_PAR_CFG = 5'h11;
  localparam logic [4:0] IDX_PD_STATUS = 5'h12;

  // Field positions
  localparam int APD_FDC_BIT = 0;
  localparam int APD_PAR_BIT = 3;
  localparam int APD_SER0_BIT = 4;
  localparam int APD_SER1_BIT = 5;
  localparam int DOC_MOTOR_LO = 4;
  localparam int DOC_RESET_REL_BIT = 2;
  localparam int RATE_SWRESET_BIT = 7;
  localparam int RATE_PD_BIT = 6;
  localparam int PAR_EPP_EN_BIT = 3;
  localparam int PAR_ECP_EN_BIT = 4;

  // Reset values
  localparam logic [7:0] DOC_RESET = 8'h00;
  localparam logic [7:0] APD_CFG_RESET = 8'h00;
  localparam logic [7:0] PAR_CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_CTRL_RESET = 8'h00;
  localparam logic [7:0] MSR_IDLE = 8'h80;

  // Extended control mode field
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_BIDIR = 3'h1;
  localparam logic [2:0] ECR_EPP = 3'h4;

  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int APD_TIME_MS = 10;
  localparam int APD_CYCLES = APD_TIME_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 20;

  // Pin synchroniser width: 2 receive, 2 ring, 5 drive inputs
  localparam int SYNC_W = 9;
  // Clocks after reset before pin edges count
  localparam logic [2:0] SYNC_SETTLE = 3'h5;

  typedef enum logic [2:0] {
    FD_AWAKE = 3'b001,
    FD_AUTO_PD = 3'b010,
    FD_RATE_PD = 3'b100
  } pap_fd_state_e;

  typedef struct packed {
    logic txHoldEmpty;
    logic txShiftEmpty;
    logic rxFifoEmpty;
    logic rxIdle;
  } pap_ser_stat_s;

  typedef struct packed {
    logic writeData;
    logic writeGate;
    logic seekHeading;
    logic stepPulse;
    logic headSelect;
    logic [1:0] densitySelect;
  } pap_drive_core_s;

endpackage : pap_pkg

// ==== rtl/pap_power_mgr.sv ====
// Chosen here: the Wishbone slave port.
module pap_power_mgr #(
  parameter int unsigned APD_CYCLES = pap_pkg::APD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Floppy core status
  input wire logic [7:0] mainStatus,
  input wire logic [7:0] statusA,
  input wire logic [7:0] statusB,
  input wire logic [7:0] coreReadData,
  input wire logic fdcIrq,
  input wire logic headUnloadDone,
  input wire pap_pkg::pap_drive_core_s driveCore,
  // Floppy core control
  output logic fdcReset,
  output logic fdcPowerdown,
  output logic dataWrStb,
  output logic dataRdStb,
  output logic [7:0] dataWrByte,
  output logic [7:0] configCtrl,
  output logic [4:0] driveInSync,
  // Drive, serial receive and ring pins
  input wire logic [1:0] serial_receive_input,
  input wire logic [1:0] phone_ring_input,
  input wire logic read_data_in,
  input wire logic write_protect_in,
  input wire logic track_zero_in,
  input wire logic index_pulse_in,
  input wire logic disk_change_in,
  output logic motor_out0,
  output logic motor_out0_oe_b,
  output logic drive_select0,
  output logic drive_select0_oe_b,
  output logic write_data_out,
  output logic write_data_out_oe_b,
  output logic write_gate_out,
  output logic write_gate_out_oe_b,
  output logic seek_heading_out,
  output logic step_pulse_out,
  output logic head_select_out,
  output logic [1:0] density_select_out,
  // Serial units
  input wire pap_pkg::pap_ser_stat_s [1:0] serStat,
  input wire logic [1:0] transmitBufWrite,
  output logic [1:0] txPowerdown,
  output logic [1:0] rxPowerdown,
  output logic [1:0] ringChange,
  // Parallel unit
  output logic eppPowerdown,
  output logic ecpPowerdown
);

  pap_pkg::pap_fd_state_e fdState_q;
  logic [7:0] driveOutCtrl_q;
  logic [7:0] autoPdCfg_q;
  logic [7:0] parCfg_q;
  logic [pap_pkg::TMR_W-1:0] apdCnt_q;
  logic [pap_pkg::SYNC_W-1:0] sync0_q;
  logic [pap_pkg::SYNC_W-1:0] sync1_q;
  logic [pap_pkg::SYNC_W-1:0] sync2_q;
  logic [pap_pkg::SYNC_W-1:0] pinStable_q;
  logic [pap_pkg::SYNC_W-1:0] pinPrev_q;
  logic [2:0] syncFill_q;
  logic [7:0] rdByte;
  logic busTake;
  logic busFire;
  logic wrLow;
  logic [4:0] regIdx;
  logic motorSetWr;
  logic softResetWr;
  logic ratePdWr;
  logic statusRd;
  logic dataAcc;
  logic fdWake;
  logic fdAsleep;
  logic timerDone;
  logic fdIdle;
  logic [1:0] rxEdge;
  logic [1:0] ringEdge;

  // Bus handshake: request taken one cycle, acked the next
  assign busTake = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busFire = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wrLow = busFire && wb_we_i && wb_sel_i[0];
  assign regIdx = wb_adr_i[6:2];

  // Wake decode, only the register the access really lands on counts
  assign motorSetWr = wrLow && regIdx == pap_pkg::IDX_DRIVE_OUT_CTRL &&
    wb_dat_i[pap_pkg::DOC_MOTOR_LO +: 4] != 4'h0;
  assign softResetWr = wrLow &&
    ((regIdx == pap_pkg::IDX_DRIVE_OUT_CTRL && !wb_dat_i[pap_pkg::DOC_RESET_REL_BIT]) ||
     (regIdx == pap_pkg::IDX_RATE_SEL_MAIN_STAT &&
      wb_dat_i[pap_pkg::RATE_SWRESET_BIT]));
  assign ratePdWr = wrLow && regIdx == pap_pkg::IDX_RATE_SEL_MAIN_STAT &&
    wb_dat_i[pap_pkg::RATE_PD_BIT] && !wb_dat_i[pap_pkg::RATE_SWRESET_BIT];
  assign statusRd = busFire && !wb_we_i && regIdx == pap_pkg::IDX_RATE_SEL_MAIN_STAT;
  assign dataAcc = busFire && regIdx == pap_pkg::IDX_CMD_DATA &&
    (!wb_we_i || wb_sel_i[0]);
  assign fdWake = motorSetWr || softResetWr || statusRd || dataAcc;
  assign fdAsleep = fdState_q != pap_pkg::FD_AWAKE;

  // Read mux: status reads pass straight through even while asleep
  always_comb begin
    rdByte = 8'h00;
    unique case (regIdx)
      pap_pkg::IDX_STATUS_A: rdByte = statusA;
      pap_pkg::IDX_STATUS_B: rdByte = statusB;
      pap_pkg::IDX_DRIVE_OUT_CTRL: rdByte = driveOutCtrl_q;
      pap_pkg::IDX_RATE_SEL_MAIN_STAT: rdByte = mainStatus;
      pap_pkg::IDX_CMD_DATA: rdByte = coreReadData;
      pap_pkg::IDX_DISK_IN_CFG_CTRL: rdByte = {pinStable_q[8], 7'h00};
      pap_pkg::IDX_AUTO_PD_CFG: rdByte = autoPdCfg_q;
      pap_pkg::IDX_PAR_CFG: rdByte = parCfg_q;
      pap_pkg::IDX_PD_STATUS: rdByte = {eppPowerdown, ecpPowerdown, rxPowerdown,
                                        txPowerdown, fdState_q == pap_pkg::FD_RATE_PD,
                                        fdState_q == pap_pkg::FD_AUTO_PD};
      default: rdByte = 8'h00;
    endcase
  end

  // Bus slave runs on regardless of powerdown so waking accesses are seen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busTake;
      if (busTake) begin
        wb_dat_o <= {24'h0, rdByte};
      end
    end
  end

  // Written values are held whatever the sleep state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      driveOutCtrl_q <= pap_pkg::DOC_RESET;
      autoPdCfg_q <= pap_pkg::APD_CFG_RESET;
      parCfg_q <= pap_pkg::PAR_CFG_RESET;
      configCtrl <= pap_pkg::CFG_CTRL_RESET;
    end else if (wrLow) begin
      unique case (regIdx)
        pap_pkg::IDX_DRIVE_OUT_CTRL: driveOutCtrl_q <= wb_dat_i[7:0];
        pap_pkg::IDX_DISK_IN_CFG_CTRL: configCtrl <= wb_dat_i[7:0];
        pap_pkg::IDX_AUTO_PD_CFG: autoPdCfg_q <= wb_dat_i[7:0];
        pap_pkg::IDX_PAR_CFG: parCfg_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Data port strobes towards the controller core
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dataWrStb <= 1'b0;
      dataRdStb <= 1'b0;
      dataWrByte <= 8'h00;
    end else begin
      dataWrStb <= dataAcc && wb_we_i;
      dataRdStb <= dataAcc && !wb_we_i;
      if (dataAcc && wb_we_i) begin
        dataWrByte <= wb_dat_i[7:0];
      end
    end
  end

  // Controller reset: held by the release bit, pulsed by the rate reset bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fdcReset <= 1'b1;
    end else begin
      fdcReset <= !driveOutCtrl_q[pap_pkg::DOC_RESET_REL_BIT] || softResetWr;
    end
  end

  assign timerDone = apdCnt_q == pap_pkg::TMR_W'(APD_CYCLES);
  assign fdIdle = driveOutCtrl_q[pap_pkg::DOC_MOTOR_LO +: 4] == 4'h0 &&
    mainStatus == pap_pkg::MSR_IDLE && !fdcIrq;

  // Auto powerdown timer, cleared while disabled and on each wake
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      apdCnt_q <= '0;
    end else if (!autoPdCfg_q[pap_pkg::APD_FDC_BIT] || fdWake) begin
      apdCnt_q <= '0;
    end else if (!timerDone) begin
      apdCnt_q <= apdCnt_q + 1'b1;
    end
  end

  // Floppy powerdown state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fdState_q <= pap_pkg::FD_AWAKE;
    end else begin
      unique case (fdState_q)
        pap_pkg::FD_AWAKE: begin
          if (ratePdWr) begin
            fdState_q <= pap_pkg::FD_RATE_PD;
          end else if (autoPdCfg_q[pap_pkg::APD_FDC_BIT] && fdIdle && headUnloadDone &&
                       timerDone && !fdWake) begin
            fdState_q <= pap_pkg::FD_AUTO_PD;
          end
        end
        pap_pkg::FD_AUTO_PD: begin
          if (ratePdWr) begin
            fdState_q <= pap_pkg::FD_RATE_PD;
          end else if (fdWake || !autoPdCfg_q[pap_pkg::APD_FDC_BIT]) begin
            fdState_q <= pap_pkg::FD_AWAKE;
          end
        end
        pap_pkg::FD_RATE_PD: begin
          if (fdWake) begin
            fdState_q <= pap_pkg::FD_AWAKE;
          end
        end
        default: fdState_q <= pap_pkg::FD_AWAKE;
      endcase
    end
  end

  // Drive outputs; only pins a drive could back-power are released
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fdcPowerdown <= 1'b0;
      motor_out0 <= 1'b1;
      drive_select0 <= 1'b1;
      write_data_out <= 1'b1;
      write_gate_out <= 1'b1;
      motor_out0_oe_b <= 1'b0;
      drive_select0_oe_b <= 1'b0;
      write_data_out_oe_b <= 1'b0;
      write_gate_out_oe_b <= 1'b0;
      seek_heading_out <= 1'b1;
      step_pulse_out <= 1'b1;
      head_select_out <= 1'b1;
      density_select_out <= 2'h0;
    end else begin
      fdcPowerdown <= fdAsleep;
      motor_out0 <= !driveOutCtrl_q[pap_pkg::DOC_MOTOR_LO];
      drive_select0 <= driveOutCtrl_q[1:0] != 2'h0;
      write_data_out <= driveCore.writeData;
      write_gate_out <= driveCore.writeGate;
      motor_out0_oe_b <= fdAsleep;
      drive_select0_oe_b <= fdAsleep;
      write_data_out_oe_b <= fdAsleep;
      write_gate_out_oe_b <= fdAsleep;
      seek_heading_out <= driveCore.seekHeading;
      step_pulse_out <= driveCore.stepPulse;
      head_select_out <= driveCore.headSelect;
      density_select_out <= driveCore.densitySelect;
    end
  end

  // Pin synchroniser: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync0_q <= '0;
      sync1_q <= '0;
      sync2_q <= '0;
      pinStable_q <= '0;
      pinPrev_q <= '0;
      syncFill_q <= 3'h0;
      driveInSync <= 5'h00;
    end else begin
      sync0_q <= {disk_change_in, index_pulse_in, track_zero_in, write_protect_in,
                  read_data_in, phone_ring_input, serial_receive_input};
      sync1_q <= sync0_q;
      sync2_q <= sync1_q;
      pinStable_q <= (sync1_q == sync2_q) ? sync2_q : pinStable_q;
      pinPrev_q <= pinStable_q;
      syncFill_q <= syncFill_q + 3'(syncFill_q != pap_pkg::SYNC_SETTLE);
      driveInSync <= pinStable_q[8:4];
    end
  end

  // Edges held off until the chain holds real levels; a pin idling high would fake one
  assign rxEdge = (syncFill_q == pap_pkg::SYNC_SETTLE) ?
    pinStable_q[1:0] ^ pinPrev_q[1:0] : 2'h0;
  assign ringEdge = (syncFill_q == pap_pkg::SYNC_SETTLE) ?
    pinStable_q[3:2] ^ pinPrev_q[3:2] : 2'h0;

  // Serial units, bits 4 and 5 select the two ports
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txPowerdown <= 2'h0;
      rxPowerdown <= 2'h0;
      ringChange <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        ringChange[i] <= ringEdge[i];
        if (!autoPdCfg_q[pap_pkg::APD_SER0_BIT + i] || transmitBufWrite[i]) begin
          txPowerdown[i] <= 1'b0;
        end else if (serStat[i].txHoldEmpty && serStat[i].txShiftEmpty) begin
          txPowerdown[i] <= 1'b1;
        end
        if (!autoPdCfg_q[pap_pkg::APD_SER0_BIT + i] || rxEdge[i]) begin
          rxPowerdown[i] <= 1'b0;
        end else if (serStat[i].rxFifoEmpty && serStat[i].rxIdle) begin
          rxPowerdown[i] <= 1'b1;
        end
      end
    end
  end

  // Parallel blocks re-evaluated every cycle from the current modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eppPowerdown <= 1'b0;
      ecpPowerdown <= 1'b0;
    end else begin
      eppPowerdown <= autoPdCfg_q[pap_pkg::APD_PAR_BIT] &&
        (!parCfg_q[pap_pkg::PAR_EPP_EN_BIT] || parCfg_q[2:0] != pap_pkg::ECR_EPP);
      ecpPowerdown <= autoPdCfg_q[pap_pkg::APD_PAR_BIT] &&
        (!parCfg_q[pap_pkg::PAR_ECP_EN_BIT] || parCfg_q[2:0] == pap_pkg::ECR_SPP ||
         parCfg_q[2:0] == pap_pkg::ECR_BIDIR || parCfg_q[2:0] == pap_pkg::ECR_EPP);
    end
  end

  sequence s_auto_asleep;
    fdState_q == pap_pkg::FD_AUTO_PD;
  endsequence

  sequence s_motor_wake;
    fdState_q == pap_pkg::FD_AUTO_PD && motorSetWr;
  endsequence

  a_enable_gate: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(fdState_q == pap_pkg::FD_AUTO_PD) |-> $past(autoPdCfg_q[0]))
    else $error("auto powerdown entered while disabled");
  a_entry_conditions: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(fdState_q == pap_pkg::FD_AUTO_PD) |-> $past(fdIdle) && $past(timerDone))
    else $error("auto powerdown entered while busy");
  a_disable_cancels: assert property (@(posedge clk) disable iff (!rst_b)
    !autoPdCfg_q[0] |=> apdCnt_q == '0 && fdState_q != pap_pkg::FD_AUTO_PD)
    else $error("disable did not cancel auto powerdown");
  a_motor_wakes: assert property (@(posedge clk) disable iff (!rst_b)
    s_motor_wake |=> fdState_q == pap_pkg::FD_AWAKE ##1 apdCnt_q == 1)
    else $error("motor write did not wake or restart timer");
  a_ctrl_read_sleeps: assert property (@(posedge clk) disable iff (!rst_b)
    s_auto_asleep and (busFire && !wb_we_i && regIdx == pap_pkg::IDX_DRIVE_OUT_CTRL
    && autoPdCfg_q[0]) |=> s_auto_asleep)
    else $error("output register read woke the unit");
  a_pins_released: assert property (@(posedge clk) disable iff (!rst_b)
    fdAsleep |=> motor_out0_oe_b && write_gate_out_oe_b && drive_select0_oe_b)
    else $error("drive outputs not released in powerdown");
  a_bus_answers: assert property (@(posedge clk) disable iff (!rst_b)
    busTake |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");
  a_tx_wake: assert property (@(posedge clk) disable iff (!rst_b)
    txPowerdown[0] && transmitBufWrite[0] |=> !txPowerdown[0])
    else $error("transmit write did not wake transmitter");
  a_ecp_mode: assert property (@(posedge clk) disable iff (!rst_b)
    autoPdCfg_q[3] && parCfg_q[2:0] == pap_pkg::ECR_EPP |=> ecpPowerdown)
    else $error("ECP logic awake in EPP mode");

endmodule : pap_power_mgr

// ==== tb/pap_far_model.sv ====
module pap_far_model (
  // Clock
  input wire logic clk,
  // Bench controls
  input wire logic coreBusy,
  input wire logic irqReq,
  input wire logic txBusy,
  input wire logic rxBusy,
  // Floppy core side
  output logic [7:0] mainStatus,
  output logic [7:0] statusA,
  output logic [7:0] statusB,
  output logic [7:0] coreReadData,
  output logic fdcIrq,
  output logic headUnloadDone,
  output pap_pkg::pap_drive_core_s driveCore,
  // Serial unit side
  output pap_pkg::pap_ser_stat_s [1:0] serStat,
  // Drive inputs
  output logic read_data_in,
  output logic write_protect_in,
  output logic track_zero_in,
  output logic index_pulse_in,
  output logic disk_change_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A busy core is not ready and keeps its heads loaded
  always_ff @(posedge clk) begin
    mainStatus <= coreBusy ? 8'h10 : 8'h80;
    headUnloadDone <= !coreBusy;
    fdcIrq <= irqReq;
  end
  assign statusA = 8'ha5;
  assign statusB = 8'h5a;
  assign coreReadData = 8'h3c;
  assign driveCore = pap_pkg::pap_drive_core_s'(7'h2a);
  // Both ports share the same tx and rx busy controls
  assign serStat[0] = {!txBusy, !txBusy, !rxBusy, 1'b1};
  assign serStat[1] = {!txBusy, !txBusy, !rxBusy, 1'b1};
  // Idle drive lines sit at their pull-up level
  assign read_data_in = 1'b1;
  assign write_protect_in = 1'b1;
  assign track_zero_in = 1'b1;
  assign index_pulse_in = 1'b1;
  assign disk_change_in = 1'b1;
endmodule : pap_far_model

// ==== tb/peripheral_auto_powerdown_tb_top.sv ====
module peripheral_auto_powerdown_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic ack, fdcIrq, headDone, fdcReset, fdcPd, ringSeen = 1'b0;
  logic coreBusy = 1'b0, irqReq = 1'b0, txBusy = 1'b0, rxBusy = 1'b0;
  logic [1:0] rxd = 2'h3, ring = 2'h0, txWr = 2'h0, densOut, txPd, rxPd, ringChg;
  logic [7:0] mainStatus, statusA, statusB, coreRd, dataWrByte, configCtrl;
  logic [3:0] oeB, drvOut;
  logic [1:0] dataStb, stbSeen = 2'h0;
  logic [4:0] inSync;
  logic seekOut, stepOut, headOut, eppPd, ecpPd, rdIn, wpIn, trkIn, idxIn, dcIn;
  pap_pkg::pap_drive_core_s driveCore;
  pap_pkg::pap_ser_stat_s [1:0] serStat;
  int errors = 0, checks_done = 0;
  logic [7:0] pc [5] = '{8'h00, 8'h1c, 8'h13, 8'h11, 8'h18};
  logic [1:0] pe [5] = '{2'b11, 2'b01, 2'b10, 2'b11, 2'b11};

  pap_power_mgr #(.APD_CYCLES(20)) pap_power_mgr_inst (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mainStatus(mainStatus), .statusA(statusA), .statusB(statusB), .coreReadData(coreRd),
    .fdcIrq(fdcIrq), .headUnloadDone(headDone), .driveCore(driveCore),
    .fdcReset(fdcReset), .fdcPowerdown(fdcPd), .dataWrStb(dataStb[1]), .dataRdStb(dataStb[0]),
    .dataWrByte(dataWrByte), .configCtrl(configCtrl), .driveInSync(inSync),
    .serial_receive_input(rxd), .phone_ring_input(ring), .read_data_in(rdIn),
    .write_protect_in(wpIn), .track_zero_in(trkIn), .index_pulse_in(idxIn),
    .disk_change_in(dcIn), .motor_out0(drvOut[3]), .motor_out0_oe_b(oeB[3]),
    .drive_select0(drvOut[2]), .drive_select0_oe_b(oeB[2]), .write_data_out(drvOut[1]),
    .write_data_out_oe_b(oeB[1]), .write_gate_out(drvOut[0]), .write_gate_out_oe_b(oeB[0]),
    .seek_heading_out(seekOut),
    .step_pulse_out(stepOut), .head_select_out(headOut), .density_select_out(densOut),
    .serStat(serStat), .transmitBufWrite(txWr), .txPowerdown(txPd), .rxPowerdown(rxPd),
    .ringChange(ringChg), .eppPowerdown(eppPd), .ecpPowerdown(ecpPd));

  pap_far_model pap_far_model_inst (
    .clk(clk), .coreBusy(coreBusy), .irqReq(irqReq), .txBusy(txBusy), .rxBusy(rxBusy),
    .mainStatus(mainStatus), .statusA(statusA), .statusB(statusB), .coreReadData(coreRd),
    .fdcIrq(fdcIrq), .headUnloadDone(headDone), .driveCore(driveCore), .serStat(serStat),
    .read_data_in(rdIn), .write_protect_in(wpIn), .track_zero_in(trkIn),
    .index_pulse_in(idxIn), .disk_change_in(dcIn));

  always #10 clk = ~clk;
  // Sticky so a one-cycle pulse is never missed
  always @(posedge clk) if (ringChg[0] === 1'b1) ringSeen <= 1'b1;
  always @(posedge clk) stbSeen <= stbSeen | (dataStb & {2{rst_b}});

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  // Classic single cycle; the wait is bounded, a missing ack counts
  task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    chk("ack", ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd(input string name, input logic [4:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(name, r, {24'h0, e});
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: return fdcPd;
      1: return txPd[0];
      2: return rxPd[1];
      3: return txPd[1];
      default: return ringSeen;
    endcase
  endfunction : pick

  // Must reach e no sooner than lo and no later than hi cycles
  task automatic waitv(input string name, input int s, input logic e, input int lo, input int hi);
    int i;
    i = 0;
    @(negedge clk);
    while (i < hi && pick(s) !== e) begin
      @(negedge clk);
      i++;
    end
    chk(name, pick(s), e);
    chk({name, " delay"}, 32'(i >= lo), 32'h1);
    @(posedge clk);
  endtask : waitv

  task automatic hold(input string name, input int s, input logic e, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk);
      ok &= (pick(s) === e);
    end
    chk(name, ok, 1'b1);
    @(posedge clk);
  endtask : hold

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("reset pins", {fdcReset, fdcPd, oeB}, 6'h20);
    rd("unmapped", 5'h1f, 8'h00);
    bus(1'b1, 5'h02, 8'h04);
    @(negedge clk);
    chk("core reset", fdcReset, 1'b0);
    @(posedge clk);
    bus(1'b1, 5'h10, 8'h01);
    waitv("auto sleep", 0, 1'b1, 15, 30);
    chk("oe asleep", oeB, 4'hf);
    chk("active pins", {seekOut, stepOut, headOut, densOut}, 5'h0a);
    chk("drive inputs", inSync, 5'h1f);
    $display("test auto entry done");
    rd("status a", 5'h00, 8'ha5);
    rd("status b", 5'h01, 8'h5a);
    rd("drive out", 5'h02, 8'h04);
    bus(1'b0, 5'h07, 8'h00);
    bus(1'b1, 5'h07, 8'h5a);
    bus(1'b1, 5'h04, 8'h00);
    bus(1'b1, 5'h02, 8'h04);
    hold("no wake", 0, 1'b1, 5);
    chk("cfg kept", configCtrl, 8'h5a);
    rd("main status", 5'h04, 8'h80);
    waitv("status wake", 0, 1'b0, 0, 2);
    chk("oe awake", oeB, 4'h0);
    chk("drive pins", drvOut, 4'h9);
    chk("no reset", fdcReset, 1'b0);
    waitv("resleep", 0, 1'b1, 15, 30);
    bus(1'b1, 5'h05, 8'h33);
    waitv("data wake", 0, 1'b0, 0, 2);
    chk("data byte", dataWrByte, 8'h33);
    chk("data strobes", stbSeen, 2'h2);
    waitv("resleep", 0, 1'b1, 15, 30);
    rd("data read", 5'h05, 8'h3c);
    waitv("read wake", 0, 1'b0, 0, 2);
    chk("data strobes", stbSeen, 2'h3);
    $display("test wake events done");
    waitv("resleep", 0, 1'b1, 15, 30);
    bus(1'b1, 5'h02, 8'h14);
    waitv("motor wake", 0, 1'b0, 0, 2);
    hold("motor on", 0, 1'b0, 40);
    irqReq <= 1'b1;
    bus(1'b1, 5'h02, 8'h04);
    hold("irq high", 0, 1'b0, 40);
    irqReq <= 1'b0;
    coreBusy <= 1'b1;
    hold("core busy", 0, 1'b0, 40);
    coreBusy <= 1'b0;
    waitv("idle sleep", 0, 1'b1, 2, 5);
    $display("test idle conditions done");
    rd("main status", 5'h04, 8'h80);
    bus(1'b1, 5'h04, 8'h40);
    waitv("rate sleep", 0, 1'b1, 0, 3);
    rd("main status", 5'h04, 8'h80);
    waitv("rate wake", 0, 1'b0, 0, 2);
    waitv("auto again", 0, 1'b1, 15, 30);
    bus(1'b1, 5'h02, 8'h00);
    waitv("reset wake", 0, 1'b0, 0, 2);
    chk("reset held", fdcReset, 1'b1);
    bus(1'b1, 5'h02, 8'h04);
    waitv("resleep", 0, 1'b1, 15, 30);
    bus(1'b1, 5'h10, 8'h00);
    waitv("disable wake", 0, 1'b0, 0, 2);
    hold("disabled", 0, 1'b0, 40);
    $display("test rate and reset done");
    bus(1'b1, 5'h10, 8'h30);
    waitv("tx sleep", 1, 1'b1, 0, 5);
    waitv("rx sleep", 2, 1'b1, 0, 5);
    rd("pd status", 5'h12, 8'h3c);
    chk("no ring", ringSeen, 1'b0);
    ring <= 2'h1;
    waitv("ring event", 4, 1'b1, 0, 10);
    txBusy <= 1'b1;
    rxBusy <= 1'b1;
    hold("stay asleep", 1, 1'b1, 10);
    txWr <= 2'h1;
    @(posedge clk);
    txWr <= 2'h0;
    waitv("tx wake", 1, 1'b0, 0, 3);
    hold("rx asleep", 2, 1'b1, 5);
    rxd <= 2'h1;
    waitv("rx wake", 2, 1'b0, 0, 8);
    txBusy <= 1'b0;
    rxBusy <= 1'b0;
    bus(1'b1, 5'h10, 8'h00);
    hold("serial off", 3, 1'b0, 5);
    $display("test serial done");
    bus(1'b1, 5'h10, 8'h08);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 5'h11, pc[k]);
      @(negedge clk);
      chk("parallel pd", {eppPd, ecpPd}, pe[k]);
      @(posedge clk);
    end
    bus(1'b1, 5'h10, 8'h00);
    @(negedge clk);
    chk("parallel off", {eppPd, ecpPd}, 2'b00);
    @(posedge clk);
    $display("test parallel done");
    stop_test();
  end
endmodule : peripheral_auto_powerdown_tb_top
